// [hw/gpw_defines.vh]
// Register indices, field positions and reset values for the port block
`ifndef GPW_DEFINES_VH
`define GPW_DEFINES_VH
`define GPW_ADDR_W 4
`define GPW_IDX_A_DATA 4'h0
`define GPW_IDX_A_DIR 4'h1
`define GPW_IDX_A_PU 4'h2
`define GPW_IDX_A_WU 4'h3
`define GPW_IDX_B_DATA 4'h4
`define GPW_IDX_B_DIR 4'h5
`define GPW_IDX_B_PU 4'h6
`define GPW_IDX_C_DATA 4'h7
`define GPW_IDX_C_DIR 4'h8
`define GPW_IDX_C_PU 4'h9
`define GPW_IDX_D_DATA 4'hA
`define GPW_IDX_D_DIR 4'hB
`define GPW_IDX_D_PU 4'hC
`define GPW_IDX_SUP_LO 4'hD
`define GPW_IDX_SUP_HI 4'hE
`define GPW_MASK_A 8'hFF
`define GPW_MASK_B 8'hFF
`define GPW_MASK_C 8'h3F
`define GPW_MASK_D 8'h0F
`define GPW_MASK_SUP_LO 8'hFF
`define GPW_MASK_SUP_HI 8'h3F
`define GPW_RST_DATA 8'h00
`define GPW_RST_DIR 8'hFF
`define GPW_RST_PU 8'h00
`define GPW_RST_WU 8'h00
`define GPW_RST_SUP 8'h00
`define GPW_SUP_A6_HI 7
`define GPW_SUP_A3_HI 5
`define GPW_SUP_C5_HI 5
`define GPW_SUP_C4_HI 3
`define GPW_SUP_A7_HI 1
`define GPW_SUP_A2_HI 3
`define GPW_SUP_A0_HI 1
`endif

// [hw/gpw_pin_sync.v]
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
module gpw_pin_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Pins
    input wire [WIDTH-1:0] pin_async,
    output reg [WIDTH-1:0] pin_level
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1_reg <= {WIDTH{1'b1}};
            stage2_reg <= {WIDTH{1'b1}};
            stage3_reg <= {WIDTH{1'b1}};
            pin_level <= {WIDTH{1'b1}};
        end else begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // Take a change once the later two stages agree
            pin_level <= (stage2_reg & stage3_reg) | (pin_level & (stage2_reg ^ stage3_reg));
        end
    end
endmodule // gpw_pin_sync

// [hw/gpw_port.v]
// One port: data latch, direction, pull-up, pad drive and read mux
`timescale 1ns/1ps
`include "gpw_defines.vh"
module gpw_port #(
    parameter [7:0] MASK = 8'hFF
) (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Register writes
    input wire [7:0] wdata,
    input wire data_we,
    input wire dir_we,
    input wire pu_we,
    // Function selection per pin, 1 = general purpose I/O
    input wire [7:0] gpio_sel,
    // Synchronised pin levels
    input wire [7:0] pin_level,
    // Register contents
    output wire [7:0] data_rd,
    output reg [7:0] dir_reg,
    output reg [7:0] pu_reg,
    // Pad control
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe,
    output wire [7:0] pad_pullup
);
    reg [7:0] latch_reg;
    genvar i;
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            latch_reg <= `GPW_RST_DATA;
            dir_reg <= `GPW_RST_DIR & MASK;
            pu_reg <= `GPW_RST_PU;
        end else begin
            if (data_we) begin
                latch_reg <= wdata & MASK;
            end
            if (dir_we) begin
                dir_reg <= wdata & MASK;
            end
            if (pu_we) begin
                pu_reg <= wdata & MASK;
            end
        end
    end
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            // Input reads live pin, output reads latch
            assign data_rd[i] = MASK[i] & (dir_reg[i] ? pin_level[i] : latch_reg[i]);
            assign pad_oe[i] = MASK[i] & ~dir_reg[i];
            assign pad_out[i] = MASK[i] & ~dir_reg[i] & latch_reg[i];
            // Pull-up only for a digital input
            assign pad_pullup[i] = MASK[i] & pu_reg[i] & dir_reg[i] & gpio_sel[i];
        end
    endgenerate
endmodule // gpw_port

// [hw/gpw_top.v]
// Four-port general-purpose I/O block with port A wake-up and supply select
// What this block does
// - Four ports: 8, 8, 6, 4 bits.
// - Input read samples live pins, no latching.
// - Output latch holds until rewritten.
// - Direction bit 1 input, 0 output; reset 1.
// - Output pin read returns latch value.
// - Pull-up enable per pin, reset 0.
// - Pull-up only on digital input pins.
// - Port A falling edge raises wake-up.
// - Wake-up enable per port A bit, reset 0.
// - Wake-up only for GPIO input while asleep.
// - Supply field 1x alternate, 0x main.
// - High select: C5, C4, A7; 7:6 unused.
// - Alternate supply needs B4 function and 1x.
// - Supply choice only for digital I/O pins.
// - Unimplemented bits ignore writes, read zero.
`timescale 1ns/1ps
`include "gpw_defines.vh"
module gpw_top (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // CPU data memory access
    input wire [`GPW_ADDR_W-1:0] mem_addr,
    input wire mem_wr,
    input wire mem_rd,
    input wire [7:0] mem_wdata,
    output reg [7:0] mem_rdata,
    // Processor state and pin function selection
    input wire cpu_low_power,
    input wire [7:0] port_a_gpio_sel,
    input wire [7:0] port_b_gpio_sel,
    input wire [5:0] port_c_gpio_sel,
    input wire [3:0] port_d_gpio_sel,
    input wire port_b_pin4_alt_supply,
    // Port A pads
    input wire [7:0] port_a_in,
    output wire [7:0] port_a_out,
    output wire [7:0] port_a_oe,
    output wire [7:0] port_a_pullup,
    // Port B pads
    input wire [7:0] port_b_in,
    output wire [7:0] port_b_out,
    output wire [7:0] port_b_oe,
    output wire [7:0] port_b_pullup,
    // Port C pads
    input wire [5:0] port_c_in,
    output wire [5:0] port_c_out,
    output wire [5:0] port_c_oe,
    output wire [5:0] port_c_pullup,
    // Port D pads
    input wire [3:0] port_d_in,
    output wire [3:0] port_d_out,
    output wire [3:0] port_d_oe,
    output wire [3:0] port_d_pullup,
    // Supply routing, 1 = alternate supply: A0 A2 A3 A6 A7 C4 C5 at bits 0..6
    output wire [6:0] alt_supply_sel,
    // Wake-up
    output reg wakeup_req
);
    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire [7:0] rd_a;
    wire [7:0] rd_b;
    wire [7:0] rd_c;
    wire [7:0] rd_d;
    wire [7:0] dir_a;
    wire [7:0] dir_b;
    wire [7:0] dir_c;
    wire [7:0] dir_d;
    wire [7:0] pu_a;
    wire [7:0] pu_b;
    wire [7:0] pu_c;
    wire [7:0] pu_d;
    wire [7:0] out_a;
    wire [7:0] out_b;
    wire [7:0] out_c;
    wire [7:0] out_d;
    wire [7:0] oe_a;
    wire [7:0] oe_b;
    wire [7:0] oe_c;
    wire [7:0] oe_d;
    wire [7:0] pull_a;
    wire [7:0] pull_b;
    wire [7:0] pull_c;
    wire [7:0] pull_d;
    wire [7:0] lvl_a;
    wire [7:0] lvl_b;
    wire [5:0] lvl_c;
    wire [3:0] lvl_d;
    reg [7:0] wu_reg;
    reg [7:0] sup_lo_reg;
    reg [7:0] sup_hi_reg;
    reg [7:0] lvl_a_prev_reg;
    wire [7:0] sel_c;
    wire [7:0] sel_d;
    assign sel_c = {2'b00, port_c_gpio_sel};
    assign sel_d = {4'h0, port_d_gpio_sel};
    wire we_a = mem_wr && (mem_addr == `GPW_IDX_A_DATA);
    wire we_ad = mem_wr && (mem_addr == `GPW_IDX_A_DIR);
    wire we_ap = mem_wr && (mem_addr == `GPW_IDX_A_PU);
    wire we_aw = mem_wr && (mem_addr == `GPW_IDX_A_WU);
    wire we_b = mem_wr && (mem_addr == `GPW_IDX_B_DATA);
    wire we_bd = mem_wr && (mem_addr == `GPW_IDX_B_DIR);
    wire we_bp = mem_wr && (mem_addr == `GPW_IDX_B_PU);
    wire we_c = mem_wr && (mem_addr == `GPW_IDX_C_DATA);
    wire we_cd = mem_wr && (mem_addr == `GPW_IDX_C_DIR);
    wire we_cp = mem_wr && (mem_addr == `GPW_IDX_C_PU);
    wire we_d = mem_wr && (mem_addr == `GPW_IDX_D_DATA);
    wire we_dd = mem_wr && (mem_addr == `GPW_IDX_D_DIR);
    wire we_dp = mem_wr && (mem_addr == `GPW_IDX_D_PU);
    wire we_slo = mem_wr && (mem_addr == `GPW_IDX_SUP_LO);
    wire we_shi = mem_wr && (mem_addr == `GPW_IDX_SUP_HI);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    gpw_pin_sync #(.WIDTH(8)) u_sync_a (
        .core_clk(core_clk),
        .reset(reset),
        .pin_async(port_a_in),
        .pin_level(lvl_a)
    );
    gpw_pin_sync #(.WIDTH(8)) u_sync_b (
        .core_clk(core_clk),
        .reset(reset),
        .pin_async(port_b_in),
        .pin_level(lvl_b)
    );
    gpw_pin_sync #(.WIDTH(6)) u_sync_c (
        .core_clk(core_clk),
        .reset(reset),
        .pin_async(port_c_in),
        .pin_level(lvl_c)
    );
    gpw_pin_sync #(.WIDTH(4)) u_sync_d (
        .core_clk(core_clk),
        .reset(reset),
        .pin_async(port_d_in),
        .pin_level(lvl_d)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Ports, widths 8, 8, 6, 4 set by masks
    gpw_port #(.MASK(`GPW_MASK_A)) u_port_a (
        .core_clk(core_clk),
        .reset(reset),
        .wdata(mem_wdata),
        .data_we(we_a),
        .dir_we(we_ad),
        .pu_we(we_ap),
        .gpio_sel(port_a_gpio_sel),
        .pin_level(lvl_a),
        .data_rd(rd_a),
        .dir_reg(dir_a),
        .pu_reg(pu_a),
        .pad_out(out_a),
        .pad_oe(oe_a),
        .pad_pullup(pull_a)
    );
    gpw_port #(.MASK(`GPW_MASK_B)) u_port_b (
        .core_clk(core_clk),
        .reset(reset),
        .wdata(mem_wdata),
        .data_we(we_b),
        .dir_we(we_bd),
        .pu_we(we_bp),
        .gpio_sel(port_b_gpio_sel),
        .pin_level(lvl_b),
        .data_rd(rd_b),
        .dir_reg(dir_b),
        .pu_reg(pu_b),
        .pad_out(out_b),
        .pad_oe(oe_b),
        .pad_pullup(pull_b)
    );
    gpw_port #(.MASK(`GPW_MASK_C)) u_port_c (
        .core_clk(core_clk),
        .reset(reset),
        .wdata(mem_wdata),
        .data_we(we_c),
        .dir_we(we_cd),
        .pu_we(we_cp),
        .gpio_sel(sel_c),
        .pin_level({2'b00, lvl_c}),
        .data_rd(rd_c),
        .dir_reg(dir_c),
        .pu_reg(pu_c),
        .pad_out(out_c),
        .pad_oe(oe_c),
        .pad_pullup(pull_c)
    );
    gpw_port #(.MASK(`GPW_MASK_D)) u_port_d (
        .core_clk(core_clk),
        .reset(reset),
        .wdata(mem_wdata),
        .data_we(we_d),
        .dir_we(we_dd),
        .pu_we(we_dp),
        .gpio_sel(sel_d),
        .pin_level({4'h0, lvl_d}),
        .data_rd(rd_d),
        .dir_reg(dir_d),
        .pu_reg(pu_d),
        .pad_out(out_d),
        .pad_oe(oe_d),
        .pad_pullup(pull_d)
    );
    assign port_a_out = out_a;
    assign port_a_oe = oe_a;
    assign port_a_pullup = pull_a;
    assign port_b_out = out_b;
    assign port_b_oe = oe_b;
    assign port_b_pullup = pull_b;
    assign port_c_out = out_c[5:0];
    assign port_c_oe = oe_c[5:0];
    assign port_c_pullup = pull_c[5:0];
    assign port_d_out = out_d[3:0];
    assign port_d_oe = oe_d[3:0];
    assign port_d_pullup = pull_d[3:0];
    ////////////////////////////////////////////////////////////////////////////
    // Wake-up enable and supply select registers
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wu_reg <= `GPW_RST_WU;
            sup_lo_reg <= `GPW_RST_SUP;
            sup_hi_reg <= `GPW_RST_SUP;
        end else begin
            if (we_aw) begin
                wu_reg <= mem_wdata;
            end
            if (we_slo) begin
                sup_lo_reg <= mem_wdata & `GPW_MASK_SUP_LO;
            end
            if (we_shi) begin
                sup_hi_reg <= mem_wdata & `GPW_MASK_SUP_HI;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Supply routing, upper field bit picks the alternate supply
    wire [6:0] sup_field_hi;
    wire [6:0] sup_gpio;
    // Lower field bit is a don't-care: 0x main, 1x alternate
    wire pin_a0_supply_alt = sup_lo_reg[`GPW_SUP_A0_HI];
    wire pin_a2_supply_alt = sup_lo_reg[`GPW_SUP_A2_HI];
    wire pin_a3_supply_alt = sup_lo_reg[`GPW_SUP_A3_HI];
    wire pin_a6_supply_alt = sup_lo_reg[`GPW_SUP_A6_HI];
    wire pin_a7_supply_alt = sup_hi_reg[`GPW_SUP_A7_HI];
    wire pin_c4_supply_alt = sup_hi_reg[`GPW_SUP_C4_HI];
    wire pin_c5_supply_alt = sup_hi_reg[`GPW_SUP_C5_HI];
    assign sup_field_hi = {pin_c5_supply_alt, pin_c4_supply_alt,
                           pin_a7_supply_alt, pin_a6_supply_alt,
                           pin_a3_supply_alt, pin_a2_supply_alt,
                           pin_a0_supply_alt};
    assign sup_gpio = {port_c_gpio_sel[5], port_c_gpio_sel[4], port_a_gpio_sel[7],
                       port_a_gpio_sel[6], port_a_gpio_sel[3], port_a_gpio_sel[2],
                       port_a_gpio_sel[0]};
    assign alt_supply_sel = sup_field_hi & sup_gpio & {7{port_b_pin4_alt_supply}};
    ////////////////////////////////////////////////////////////////////////////
    // Port A falling-edge wake-up
    wire [7:0] wu_armed = wu_reg & dir_a & port_a_gpio_sel & {8{cpu_low_power}};
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lvl_a_prev_reg <= 8'hFF;
            wakeup_req <= 1'b0;
        end else begin
            lvl_a_prev_reg <= lvl_a;
            wakeup_req <= |(wu_armed & lvl_a_prev_reg & ~lvl_a);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read mux, registered on read strobe
    reg [7:0] rd_next;
    always @* begin
        case (mem_addr)
            `GPW_IDX_A_DATA: rd_next = rd_a;
            `GPW_IDX_A_DIR: rd_next = dir_a;
            `GPW_IDX_A_PU: rd_next = pu_a;
            `GPW_IDX_A_WU: rd_next = wu_reg;
            `GPW_IDX_B_DATA: rd_next = rd_b;
            `GPW_IDX_B_DIR: rd_next = dir_b;
            `GPW_IDX_B_PU: rd_next = pu_b;
            `GPW_IDX_C_DATA: rd_next = rd_c;
            `GPW_IDX_C_DIR: rd_next = dir_c;
            `GPW_IDX_C_PU: rd_next = pu_c;
            `GPW_IDX_D_DATA: rd_next = rd_d;
            `GPW_IDX_D_DIR: rd_next = dir_d;
            `GPW_IDX_D_PU: rd_next = pu_d;
            `GPW_IDX_SUP_LO: rd_next = sup_lo_reg;
            `GPW_IDX_SUP_HI: rd_next = sup_hi_reg;
            default: rd_next = 8'h00;
        endcase
    end
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mem_rdata <= 8'h00;
        end else if (mem_rd) begin
            mem_rdata <= rd_next;
        end
    end
    // Unbonded lines are masked off; their register bits ignore writes and read zero
endmodule // gpw_top

// [verif/gpw_pins.sv]
// Pad-side model: external drivers, pull-ups and floating pins
`timescale 1ns/1ps
module gpw_pins #(
    parameter W = 8
) (
    // Clock
    input wire core_clk,
    // Pad control from the block
    input wire [W-1:0] pad_out,
    input wire [W-1:0] pad_oe,
    input wire [W-1:0] pad_pullup,
    // External driver, strong enough to beat the pad
    input wire [W-1:0] ext_en,
    input wire [W-1:0] ext_val,
    // Level seen by the block
    output wire [W-1:0] pin
);
    logic [W-1:0] float_q = '0;
    // Undriven pin without pull-up wanders every cycle
    always @(posedge core_clk) begin
        float_q <= ~float_q;
    end
    assign pin = (ext_en & ext_val) | (~ext_en & ((pad_oe & pad_out)
        | (~pad_oe & (pad_pullup | float_q))));
endmodule // gpw_pins

// [verif/gpw_top_monitor.sv]
// Assertions on register, pad and wake-up behaviour of the port block
`timescale 1ns/1ps
`include "gpw_defines.vh"
module gpw_top_monitor (
    // Clock and reset
    input wire core_clk,
    input wire reset,
    // Register access
    input wire [`GPW_ADDR_W-1:0] mem_addr,
    input wire mem_wr,
    input wire mem_rd,
    input wire [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    // Control inputs
    input wire cpu_low_power,
    input wire [7:0] port_a_gpio_sel,
    input wire [5:0] port_c_gpio_sel,
    input wire port_b_pin4_alt_supply,
    // Pads and outputs
    input wire [7:0] port_a_out,
    input wire [7:0] port_a_oe,
    input wire [7:0] port_a_pullup,
    input wire [5:0] port_c_oe,
    input wire [5:0] port_c_pullup,
    input wire [3:0] port_d_oe,
    input wire [6:0] alt_supply_sel,
    input wire wakeup_req
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence s_a_dir_wr;
        mem_wr && mem_addr == `GPW_IDX_A_DIR;
    endsequence
    sequence s_a_dir_rd;
        mem_rd && mem_addr == `GPW_IDX_A_DIR;
    endsequence
    ////////////////////////////////////////
    chk_reset_state: assert property ($fell(reset) |-> port_a_oe == 8'h00
        && port_d_oe == 4'h0 && port_a_pullup == 8'h00 && !wakeup_req)
        else $error("outputs not idle after reset");
    chk_dir_write: assert property (s_a_dir_wr |=> port_a_oe == ~$past(mem_wdata))
        else $error("drive enable differs from direction write");
    chk_dir_read: assert property (s_a_dir_rd |=> mem_rdata == ~$past(port_a_oe))
        else $error("direction read differs from register");
    chk_c_dir_mask: assert property (mem_wr && mem_addr == `GPW_IDX_C_DIR
        |=> port_c_oe == ~$past(mem_wdata[5:0]))
        else $error("port c drive enable wrong");
    chk_latch_hold: assert property (!(mem_wr && (mem_addr == `GPW_IDX_A_DATA
        || mem_addr == `GPW_IDX_A_DIR)) |=> $stable(port_a_out))
        else $error("port a output changed without write");
    chk_out_released: assert property ((port_a_out & ~port_a_oe) == 8'h00)
        else $error("released pad carries data");
    chk_out_read: assert property (mem_rd && mem_addr == `GPW_IDX_A_DATA
        && port_a_oe == 8'hFF |=> mem_rdata == $past(port_a_out))
        else $error("output read differs from latch");
    chk_pullup_qual: assert property ((port_a_pullup & (port_a_oe | ~port_a_gpio_sel))
        == 8'h00 && (port_c_pullup & port_c_oe) == 6'h00)
        else $error("pull-up on a non-input pin");
    chk_unmapped_zero: assert property (mem_rd && mem_addr == 4'hF |=> mem_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_wake_asleep: assert property (wakeup_req |-> $past(cpu_low_power))
        else $error("wake-up while awake");
    chk_alt_needs_pin: assert property (alt_supply_sel != 7'h00 |-> port_b_pin4_alt_supply)
        else $error("alternate supply without supply pin");
    chk_alt_gpio_only: assert property ((alt_supply_sel & ~{port_c_gpio_sel[5:4],
        port_a_gpio_sel[7:6], port_a_gpio_sel[3:2], port_a_gpio_sel[0]}) == 7'h00)
        else $error("alternate supply on non-GPIO pin");
    chk_hi_fields: assert property (mem_wr && mem_addr == `GPW_IDX_SUP_HI
        && port_b_pin4_alt_supply && port_a_gpio_sel[7] && port_c_gpio_sel[5:4] == 2'h3
        |=> alt_supply_sel[6:4] == {$past(mem_wdata[5]), $past(mem_wdata[3]),
        $past(mem_wdata[1])})
        else $error("high supply fields misplaced");
endmodule // gpw_top_monitor
bind gpw_top gpw_top_monitor i_gpw_top_monitor (
    .core_clk(core_clk), .reset(reset), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .cpu_low_power(cpu_low_power), .port_a_gpio_sel(port_a_gpio_sel),
    .port_c_gpio_sel(port_c_gpio_sel), .port_b_pin4_alt_supply(port_b_pin4_alt_supply),
    .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_a_pullup(port_a_pullup),
    .port_c_oe(port_c_oe), .port_c_pullup(port_c_pullup), .port_d_oe(port_d_oe),
    .alt_supply_sel(alt_supply_sel), .wakeup_req(wakeup_req)
);

// [verif/gpw_top_test.sv]
// Register-level testbench for the four-port block
`timescale 1ns/1ps
`include "gpw_defines.vh"
module gpw_top_test;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] mem_addr = 4'h0;
    logic mem_wr = 1'b0;
    logic mem_rd = 1'b0;
    logic [7:0] mem_wdata = 8'h00;
    logic low_pwr = 1'b0;
    logic [7:0] gsel_a = 8'hFF;
    logic [7:0] gsel_r = 8'hFF;
    logic alt_b4 = 1'b1;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] rdata;
    logic [7:0] a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu;
    logic [5:0] c_in, c_out, c_oe, c_pu;
    logic [3:0] d_in, d_out, d_oe, d_pu;
    logic [6:0] alt;
    logic wake;
    logic [7:0] k;
    int failures = 0;
    int checked = 0;
    logic [7:0] rst_tab [16] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
        8'h3F, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] msk_tab [16] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00,
        8'h3F, 8'h3F, 8'h00, 8'h0F, 8'h0F, 8'hFF, 8'h3F, 8'h00};
    gpw_top i_gpw_top (.core_clk(core_clk), .reset(reset), .mem_addr(mem_addr),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(rdata),
        .cpu_low_power(low_pwr), .port_a_gpio_sel(gsel_a), .port_b_gpio_sel(gsel_r),
        .port_c_gpio_sel(gsel_r[5:0]), .port_d_gpio_sel(gsel_r[3:0]),
        .port_b_pin4_alt_supply(alt_b4), .port_a_in(a_in), .port_a_out(a_out),
        .port_a_oe(a_oe), .port_a_pullup(a_pu), .port_b_in(b_in), .port_b_out(b_out),
        .port_b_oe(b_oe), .port_b_pullup(b_pu), .port_c_in(c_in), .port_c_out(c_out),
        .port_c_oe(c_oe), .port_c_pullup(c_pu), .port_d_in(d_in), .port_d_out(d_out),
        .port_d_oe(d_oe), .port_d_pullup(d_pu), .alt_supply_sel(alt), .wakeup_req(wake));
    gpw_pins #(.W(8)) i_gpw_pins_a (.core_clk(core_clk), .pad_out(a_out), .pad_oe(a_oe),
        .pad_pullup(a_pu), .ext_en(ext_en), .ext_val(ext_val), .pin(a_in));
    gpw_pins #(.W(8)) i_gpw_pins_b (.core_clk(core_clk), .pad_out(b_out), .pad_oe(b_oe),
        .pad_pullup(b_pu), .ext_en(ext_en), .ext_val(ext_val), .pin(b_in));
    gpw_pins #(.W(6)) i_gpw_pins_c (.core_clk(core_clk), .pad_out(c_out), .pad_oe(c_oe),
        .pad_pullup(c_pu), .ext_en(ext_en[5:0]), .ext_val(ext_val[5:0]), .pin(c_in));
    gpw_pins #(.W(4)) i_gpw_pins_d (.core_clk(core_clk), .pad_out(d_out), .pad_oe(d_oe),
        .pad_pullup(d_pu), .ext_en(ext_en[3:0]), .ext_val(ext_val[3:0]), .pin(d_in));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        idle(1);
        mem_addr = a;
        mem_wdata = d;
        mem_wr = 1'b1;
        idle(1);
        mem_wr = 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        idle(1);
        mem_addr = a;
        mem_rd = 1'b1;
        idle(1);
        mem_rd = 1'b0;
        check(rdata, e);
    endtask
    // Counts wake-up pulses over a bounded window
    task wake_count(input int n);
        k = 8'h00;
        repeat (n) begin
            idle(1);
            if (wake === 1'b1) k++;
        end
    endtask
    task give_verdict;
        $display("Counts: %0d checks, %0d mismatches", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        idle(4);
        reset = 1'b0;
        check(a_oe | a_pu, 8'h00);
        // Pin synchronisers still show their reset level for a few edges
        idle(8);
        for (int i = 0; i < 16; i++) rd(i[3:0], rst_tab[i]);
        $display("reset values done");
        for (int i = 0; i < 16; i++) wr(i[3:0], 8'hFF);
        for (int i = 0; i < 16; i++) rd(i[3:0], msk_tab[i]);
        check(a_pu, 8'hFF);
        check({2'h0, c_pu}, 8'h3F);
        check(b_pu, 8'hFF);
        check({4'h0, d_pu}, 8'h0F);
        check({1'b0, alt}, 8'h7F);
        alt_b4 = 1'b0;
        idle(1);
        check({1'b0, alt}, 8'h00);
        alt_b4 = 1'b1;
        gsel_a = 8'h00;
        idle(1);
        check(a_pu, 8'h00);
        check({1'b0, alt}, 8'h60);
        gsel_a = 8'hFF;
        gsel_r = 8'h00;
        idle(1);
        check({2'h0, c_pu}, 8'h00);
        check(b_pu | {4'h0, d_pu}, 8'h00);
        check({1'b0, alt}, 8'h1F);
        gsel_r = 8'hFF;
        wr(`GPW_IDX_SUP_HI, 8'h15);
        check({1'b0, alt}, 8'h0F);
        wr(`GPW_IDX_SUP_LO, 8'h80);
        check({1'b0, alt}, 8'h08);
        wr(`GPW_IDX_SUP_LO, 8'h20);
        check({1'b0, alt}, 8'h04);
        ext_en = 8'h00;
        idle(8);
        rd(`GPW_IDX_C_DATA, 8'h3F);
        ext_en = 8'hFF; // Every bonded line driven; C and D models take only ext_en[5:0] and [3:0]
        $display("masks and supply done");
        wr(`GPW_IDX_A_DIR, 8'h00);
        wr(`GPW_IDX_A_DATA, 8'h5A);
        check(a_oe, 8'hFF);
        check(a_out, 8'h5A);
        check(a_pu, 8'h00);
        idle(8);
        rd(`GPW_IDX_A_DATA, 8'h5A);
        wr(`GPW_IDX_A_DIR, 8'hFF);
        check(a_out | a_oe, 8'h00);
        wr(`GPW_IDX_A_DIR, 8'h00);
        check(a_out, 8'h5A);
        wr(`GPW_IDX_D_DIR, 8'h00);
        wr(`GPW_IDX_D_DATA, 8'hFF);
        check({4'h0, d_out}, 8'h0F);
        rd(`GPW_IDX_D_DATA, 8'h0F);
        wr(`GPW_IDX_B_DIR, 8'h00);
        wr(`GPW_IDX_B_DATA, 8'hA5);
        check(b_oe, 8'hFF);
        check(b_out, 8'hA5);
        check(b_pu, 8'h00);
        wr(`GPW_IDX_C_DIR, 8'h00);
        wr(`GPW_IDX_C_DATA, 8'hFF);
        check({2'h0, c_out}, 8'h3F);
        wr(`GPW_IDX_B_DIR, 8'hFF);
        wr(`GPW_IDX_C_DIR, 8'hFF);
        check(b_out | b_oe, 8'h00);
        wr(`GPW_IDX_A_DIR, 8'hFF);
        wr(`GPW_IDX_D_DIR, 8'hFF);
        $display("output latch done");
        for (int j = 0; j < 2; j++) begin
            ext_val = j ? 8'h3C : 8'hC3;
            idle(8);
            rd(`GPW_IDX_A_DATA, ext_val);
            rd(`GPW_IDX_B_DATA, ext_val);
            rd(`GPW_IDX_C_DATA, ext_val & 8'h3F);
        end
        $display("live input done");
        ext_val = 8'hFF;
        low_pwr = 1'b1;
        idle(8);
        ext_val = 8'hF7;
        wake_count(12);
        check(k, 8'h01);
        low_pwr = 1'b0;
        ext_val = 8'hFF;
        idle(8);
        ext_val = 8'hFE;
        wake_count(12);
        check(k, 8'h00);
        low_pwr = 1'b1;
        ext_val = 8'hFF;
        idle(8);
        wr(`GPW_IDX_A_WU, 8'hF7);
        ext_val = 8'hF7;
        wake_count(12);
        check(k, 8'h00);
        ext_val = 8'hF6;
        wake_count(12);
        check(k, 8'h01);
        $display("wake-up done");
        give_verdict();
    end
endmodule // gpw_top_test
